// file: core/rgbctl_pkg.sv
// Package of constants for the RGB driver host controller
`default_nettype none
package rgbctl_pkg;
    localparam int CLK_MHZ = 250;
    // Least low time on the enable pin, in ns
    localparam int OE_LOW_MIN_NS = 1000;
    localparam int OE_LOW_MIN_CYC = (OE_LOW_MIN_NS * CLK_MHZ + 999) / 1000;
    // Least high time on the enable pin, in ns
    localparam int OE_HIGH_MIN_NS = 5000;
    localparam int OE_HIGH_MIN_CYC = (OE_HIGH_MIN_NS * CLK_MHZ + 999) / 1000;
    // Wake turn-on time, in ns
    localparam int WAKE_NS = 1400;
    localparam int WAKE_CYC = (WAKE_NS * CLK_MHZ + 999) / 1000;
    // Sleep entry delay, in ms (typical and longest)
    localparam int SLEEP_TYP_MS = 4;
    localparam int SLEEP_MAX_MS = 8;
    localparam int SLEEP_MAX_CYC = SLEEP_MAX_MS * CLK_MHZ * 1000;
    localparam int CNT_W = 24;
    localparam int NCH = 3;
    localparam logic [NCH-1:0] GATE_RST = 3'h0;
    typedef enum logic [1:0] {RGBCTL_OFF, RGBCTL_ON, RGBCTL_LOW, RGBCTL_SLEEP} rgbctl_state_t;
endpackage : rgbctl_pkg
`default_nettype wire

// file: core/rgbctl_if.sv
// Interface between the controller and its timing counter
`default_nettype none
interface rgbctl_if;
    logic clear;
    logic [rgbctl_pkg::CNT_W-1:0] count;
    modport ctl (output clear, input count);
    modport tmr (input clear, output count);
endinterface : rgbctl_if
`default_nettype wire

// file: core/rgbctl_timer.sv
// Saturating cycle counter, restarted by clear
`default_nettype none
module rgbctl_timer (
    input wire logic clk,
    input wire logic rst_n,
    rgbctl_if.tmr t
);
    // Saturates so a long sleep never wraps back to a short time
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            t.count <= '0;
        end else if (t.clear) begin
            t.count <= '0;
        end else if (t.count != {rgbctl_pkg::CNT_W{1'b1}}) begin
            t.count <= t.count + 1'b1;
        end
    end
endmodule : rgbctl_timer
`default_nettype wire

// file: core/rgbctl_host.sv
// Host controller driving the gate and enable pins of the LED driver
`default_nettype none
module rgbctl_host #(
    parameter int SLEEP_CYC = rgbctl_pkg::SLEEP_MAX_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [rgbctl_pkg::NCH-1:0] gate_req,
    input wire logic enable_req,
    input wire logic supply_ok,
    input wire logic thermal_fault,
    output logic [rgbctl_pkg::NCH-1:0] channel_gate_input,
    output logic output_enable,
    output logic sleep_expected,
    output logic lit_expected
);
    logic [1:0] ok_sync;
    logic [1:0] hot_sync;
    logic supply_good;
    logic hot;
    logic want_on;
    rgbctl_pkg::rgbctl_state_t state;
    rgbctl_pkg::rgbctl_state_t next_state;
    rgbctl_if tif ();

    rgbctl_timer u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .t(tif)
    );

    // Pin inputs pass two flops before use
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ok_sync <= 2'h0;
            hot_sync <= 2'h0;
        end else begin
            ok_sync <= {ok_sync[0], supply_ok};
            hot_sync <= {hot_sync[0], thermal_fault};
        end
    end
    assign supply_good = ok_sync[1];
    assign hot = hot_sync[1];
    assign want_on = enable_req && supply_good && !hot;

    // Gates always driven to a defined level, never left open
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            channel_gate_input <= rgbctl_pkg::GATE_RST;
        end else begin
            channel_gate_input <= gate_req;
        end
    end

    // Enable phase sequencing; min low time kept by holding state, min high time too except on fault or lockout
    always_comb begin
        next_state = state;
        case (state)
            rgbctl_pkg::RGBCTL_OFF: begin
                if (want_on && tif.count >= rgbctl_pkg::CNT_W'(rgbctl_pkg::OE_LOW_MIN_CYC)) begin
                    next_state = rgbctl_pkg::RGBCTL_ON;
                end
            end
            rgbctl_pkg::RGBCTL_ON: begin
                // Short enable high pulses are stretched to keep the driver's high time
                if (!want_on && (tif.count >= rgbctl_pkg::CNT_W'(rgbctl_pkg::OE_HIGH_MIN_CYC)
                        || hot || !supply_good)) begin
                    next_state = rgbctl_pkg::RGBCTL_LOW;
                end
            end
            rgbctl_pkg::RGBCTL_LOW: begin
                if (want_on && tif.count >= rgbctl_pkg::CNT_W'(rgbctl_pkg::OE_LOW_MIN_CYC)) begin
                    next_state = rgbctl_pkg::RGBCTL_ON;
                end else if (tif.count >= rgbctl_pkg::CNT_W'(SLEEP_CYC)) begin
                    next_state = rgbctl_pkg::RGBCTL_SLEEP;
                end
            end
            rgbctl_pkg::RGBCTL_SLEEP: begin
                if (want_on) begin
                    next_state = rgbctl_pkg::RGBCTL_ON;
                end
            end
            default: begin
                next_state = rgbctl_pkg::RGBCTL_OFF;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= rgbctl_pkg::RGBCTL_OFF;
        end else begin
            state <= next_state;
        end
    end

    // Timer restarts on every phase change
    assign tif.clear = (next_state != state);

    // Enable pin follows the next phase so it is a flop output
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            output_enable <= 1'b0;
        end else begin
            output_enable <= (next_state == rgbctl_pkg::RGBCTL_ON);
        end
    end

    // Expected device view, usable by software or a monitor
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sleep_expected <= 1'b0;
            lit_expected <= 1'b0;
        end else begin
            sleep_expected <= (next_state == rgbctl_pkg::RGBCTL_SLEEP);
            lit_expected <= (next_state == rgbctl_pkg::RGBCTL_ON)
                && (gate_req != rgbctl_pkg::GATE_RST);
        end
    end

    // Run lengths of the enable pin, for the timing checks only
    // Saturating, so a long sleep can never wrap into a short run
    logic [rgbctl_pkg::CNT_W-1:0] low_run;
    logic [rgbctl_pkg::CNT_W-1:0] high_run;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_run <= '0;
        end else if (output_enable) begin
            low_run <= '0;
        end else if (low_run != {rgbctl_pkg::CNT_W{1'h1}}) begin
            low_run <= low_run + 1'h1;
        end
    end

    // High run, measured the same way
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            high_run <= '0;
        end else if (!output_enable) begin
            high_run <= '0;
        end else if (high_run != {rgbctl_pkg::CNT_W{1'h1}}) begin
            high_run <= high_run + 1'h1;
        end
    end

    // Enable edges; a fall forced by fault or lockout skips the high time
    sequence s_enable_rise;
        $rose(output_enable);
    endsequence
    sequence s_timed_fall;
        $fell(output_enable) && $past(supply_good) && !$past(hot);
    endsequence
    sequence s_low_expired;
        state == rgbctl_pkg::RGBCTL_LOW && !want_on
            && tif.count >= rgbctl_pkg::CNT_W'(SLEEP_CYC);
    endsequence

    // Low phase on the enable pin lasts at least the least low time
    a_low_min_time: assert property (@(posedge clk) disable iff (!rst_n)
        s_enable_rise |-> low_run >= rgbctl_pkg::CNT_W'(rgbctl_pkg::OE_LOW_MIN_CYC))
        else $error("enable low pulse shorter than least low time");

    // Dimming rate bounded by the least high time
    a_high_min_time: assert property (@(posedge clk) disable iff (!rst_n)
        s_timed_fall |-> high_run >= rgbctl_pkg::CNT_W'(rgbctl_pkg::OE_HIGH_MIN_CYC))
        else $error("enable high pulse shorter than least high time");

    a_rise_wanted: assert property (@(posedge clk) disable iff (!rst_n)
        s_enable_rise |-> $past(want_on))
        else $error("enable raised without a clean request");

    // Fault drops the enable within one cycle, even inside the high time
    a_fault_forces_off: assert property (@(posedge clk) disable iff (!rst_n)
        hot |=> !output_enable)
        else $error("enable raised during thermal fault");

    a_lockout_off: assert property (@(posedge clk) disable iff (!rst_n)
        !supply_good |=> !output_enable)
        else $error("enable raised under supply lockout");

    a_gate_follow: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> channel_gate_input == $past(gate_req))
        else $error("gate pins do not follow request");

    a_wake_fast: assert property (@(posedge clk) disable iff (!rst_n)
        (state == rgbctl_pkg::RGBCTL_SLEEP && want_on) |=> output_enable)
        else $error("wake from sleep too slow");

    a_sleep_flag: assert property (@(posedge clk) disable iff (!rst_n)
        sleep_expected |-> !output_enable && !lit_expected)
        else $error("sleep flagged while enabled");

    a_lit_needs_en: assert property (@(posedge clk) disable iff (!rst_n)
        lit_expected |-> output_enable)
        else $error("lit while enable low");

    a_sleep_bound: assert property (@(posedge clk) disable iff (!rst_n)
        state == rgbctl_pkg::RGBCTL_LOW |-> tif.count <= rgbctl_pkg::CNT_W'(SLEEP_CYC))
        else $error("sleep entry later than longest delay");

    // Sleep is flagged once the low run passes the longest entry delay
    a_sleep_entry: assert property (@(posedge clk) disable iff (!rst_n)
        s_low_expired |=> sleep_expected)
        else $error("sleep not flagged after longest delay");

    a_sleep_after_low: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(sleep_expected) |-> low_run > rgbctl_pkg::CNT_W'(SLEEP_CYC))
        else $error("sleep flagged before the low run expired");

    a_wake_clears: assert property (@(posedge clk) disable iff (!rst_n)
        (state == rgbctl_pkg::RGBCTL_SLEEP && want_on) |=> !sleep_expected)
        else $error("sleep flag kept after wake");
endmodule : rgbctl_host
`default_nettype wire

// file: bench/rgbctl_led_model.sv
// Behavioural model of the three-channel LED driver
`default_nettype none
module rgbctl_led_model #(
    parameter int SLEEP_CYC = 400
) (
    input wire logic clk,
    input wire logic [2:0] channel_gate_input,
    input wire logic output_enable,
    input wire logic supply_ok,
    input wire logic thermal_fault,
    output logic [2:0] channel_sink_output,
    output logic asleep
);
    timeunit 1ns;
    timeprecision 1ps;
    int low_cnt = 0;
    // Pin has no clock, so the bench clock meters the low time
    always @(posedge clk or posedge output_enable) begin
        if (output_enable) low_cnt <= 0;
        else if (low_cnt < SLEEP_CYC) low_cnt <= low_cnt + 1;
    end
    // Worst-case entry delay, so the host never sees sleep late
    assign asleep = (low_cnt >= SLEEP_CYC);
    // Sinks gated by enable, lockout and thermal fault
    assign channel_sink_output = channel_gate_input &
        {3{output_enable & supply_ok & ~thermal_fault}};
endmodule : rgbctl_led_model
`default_nettype wire

// file: bench/test_rgbctl_host.sv
// Self-checking bench of the LED driver host controller
`default_nettype none
module test_rgbctl_host;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SLP = 400;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] gate_req = 3'h0;
    logic enable_req = 1'b0;
    logic supply_ok = 1'b0;
    logic thermal_fault = 1'b0;
    logic [2:0] gates;
    logic [2:0] sink;
    logic oe, sleep_exp, lit, asleep;
    int fail_count = 0;
    int n_compared = 0;
    // 250 MHz clock
    always #2 clk = ~clk;
    rgbctl_host #(.SLEEP_CYC(SLP)) rgbctl_host_i (.clk(clk), .rst_n(rst_n),
        .gate_req(gate_req), .enable_req(enable_req), .supply_ok(supply_ok),
        .thermal_fault(thermal_fault), .channel_gate_input(gates), .output_enable(oe),
        .sleep_expected(sleep_exp), .lit_expected(lit));
    rgbctl_led_model #(.SLEEP_CYC(SLP)) rgbctl_led_model_i (.clk(clk),
        .channel_gate_input(gates), .output_enable(oe), .supply_ok(supply_ok),
        .thermal_fault(thermal_fault), .channel_sink_output(sink), .asleep(asleep));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic chk(input logic [2:0] seen, input logic [2:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude
    task automatic t_gates();
        @(posedge clk);
        supply_ok <= 1'h1;
        enable_req <= 1'h1;
        cyc(300);
        for (int g = 0; g < 8; g++) begin
            @(posedge clk) gate_req <= g[2:0];
            cyc(2);
            chk(gates, g[2:0]);
            chk(sink, g[2:0]);
            chk(3'(lit), 3'(g != 0));
        end
    endtask : t_gates
    task automatic t_sleep();
        cyc(1300);
        @(posedge clk) enable_req <= 1'b0;
        cyc(2);
        chk(sink, 3'h0);
        cyc(SLP - 10);
        chk(3'(sleep_exp), 3'h0);
        cyc(14);
        chk(3'(sleep_exp), 3'h1);
        chk(3'(asleep), 3'h1);
        @(posedge clk) enable_req <= 1'b1;
        cyc(2);
        chk(3'(sleep_exp), 3'h0);
        chk(sink, 3'h7);
    endtask : t_sleep
    task automatic t_short();
        cyc(1300);
        @(posedge clk) enable_req <= 1'b0;
        cyc(10);
        @(posedge clk) enable_req <= 1'b1;
        cyc(100);
        chk(3'(oe), 3'h0);
        cyc(200);
        chk(3'(oe), 3'h1);
        // A short high request must still give the full high time
        @(posedge clk) enable_req <= 1'h0;
        cyc(100);
        chk(3'(oe), 3'h1);
        cyc(1100);
        chk(3'(oe), 3'h0);
        @(posedge clk) enable_req <= 1'h1;
        cyc(300);
        chk(3'(oe), 3'h1);
    endtask : t_short
    task automatic t_fault();
        @(posedge clk) thermal_fault <= 1'b1;
        cyc(4);
        chk({oe, sink[1:0]}, 3'h0);
        @(posedge clk) thermal_fault <= 1'b0;
        cyc(300);
        chk(sink, 3'h7);
        @(posedge clk) supply_ok <= 1'b0;
        cyc(4);
        chk({oe, sink[1:0]}, 3'h0);
        @(posedge clk) supply_ok <= 1'b1;
        cyc(300);
        chk(sink, 3'h7);
    endtask : t_fault
    // Hang guard, over three times the expected run
    initial begin
        #80000;
        fail_count++;
        conclude();
    end
    // Main sequence
    initial begin
        cyc(20);
        @(posedge clk) rst_n <= 1'b1;
        t_gates();
        t_sleep();
        t_short();
        t_fault();
        conclude();
    end
endmodule : test_rgbctl_host
`default_nettype wire
